// *** logic/lcdcmd_decoder.sv ***
module lcdcmd_decoder (
  // Clock and reset
  input  wire  logic        sys_clk,
  input  wire  logic        rst,
  // Host pins, asynchronous to sys_clk
  input  wire  logic        host_write_strobe,
  input  wire  logic        host_is_command,
  input  wire  logic [7:0]  host_data,
  // Line pitch in addresses, from the scroll setup logic
  input  wire  logic [15:0] line_pitch,
  // Register contents
  output logic              display_enable,
  output logic [1:0]        cursor_flash_select,
  output logic [1:0]        block1_show,
  output logic [1:0]        block2_4_show,
  output logic [1:0]        block3_show,
  output logic [3:0]        cursor_width_field,
  output logic [3:0]        cursor_height_field,
  output logic              cursor_block_select,
  output logic [1:0]        cursor_direction,
  output logic [15:0]       cursor_address,
  // Display memory write port
  output logic              mem_write_en,
  output logic [15:0]       mem_write_addr,
  output logic [7:0]        mem_write_data
);
  import lcdcmd_pkg::*;

  logic [2:0]    strobe_sync_reg;
  logic [1:0]    is_cmd_sync_reg;
  logic [7:0]    data_sync1_reg;
  logic [7:0]    data_sync2_reg;
  logic          take_byte;
  lcdcmd_state_t state_reg;
  lcdcmd_state_t state_next;
  logic [7:0]    screen_attribute_reg;
  logic [7:0]    cursor_width_reg;
  logic [7:0]    cursor_height_shape_reg;
  logic [7:0]    cursor_direction_reg;
  logic [7:0]    cursor_address_low_reg;
  logic [7:0]    cursor_address_high_reg;
  logic          display_enable_reg;
  logic          is_param;
  logic          is_cmd;

  // Wraps modulo 2^16; up and down moves use the pitch from scroll setup
  function automatic logic [15:0] step_addr(input logic [15:0] addr,
                                            input logic [1:0]  dir,
                                            input logic [15:0] pitch);
    case (dir)
      DIR_RIGHT: step_addr = addr + 16'h0001;
      DIR_LEFT:  step_addr = addr - 16'h0001;
      DIR_UP:    step_addr = addr - pitch;
      default:   step_addr = addr + pitch;
    endcase
  endfunction : step_addr

  // Two flops before use; strobe gets a third for edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strobe_sync_reg <= 3'h0;
      is_cmd_sync_reg <= 2'h0;
      data_sync1_reg  <= RST_BYTE;
      data_sync2_reg  <= RST_BYTE;
    end else begin
      strobe_sync_reg <= {strobe_sync_reg[1:0], host_write_strobe};
      is_cmd_sync_reg <= {is_cmd_sync_reg[0], host_is_command};
      data_sync1_reg  <= host_data;
      data_sync2_reg  <= data_sync1_reg;
    end
  end

  // Limitation: a strobe high or low for under three clocks may be missed
  // Data must be stable while the strobe is high, so it is sampled on the rising edge
  assign take_byte = strobe_sync_reg[1] & ~strobe_sync_reg[2];
  assign is_cmd    = take_byte & is_cmd_sync_reg[1];
  assign is_param  = take_byte & ~is_cmd_sync_reg[1];

  // Unknown codes park in ST_SKIP, so their parameters are dropped
  always_comb begin
    state_next = state_reg;
    // Any new command aborts whatever sequence was open
    if (is_cmd) begin
      case (data_sync2_reg)
        CMD_SCREEN_OFF, CMD_SCREEN_ON: state_next = ST_SCREEN_1;
        CMD_CURSOR_LOAD:               state_next = ST_LOAD_1;
        CMD_CURSOR_SHAPE:              state_next = ST_SHAPE_1;
        CMD_MEMORY_STORE:              state_next = ST_STORE;
        default:                       state_next = ST_SKIP;
      endcase
    end else if (is_param) begin
      case (state_reg)
        ST_SCREEN_1: state_next = ST_SKIP;
        ST_LOAD_1:   state_next = ST_LOAD_2;
        ST_LOAD_2:   state_next = ST_SKIP;
        ST_SHAPE_1:  state_next = ST_SHAPE_2;
        ST_SHAPE_2:  state_next = ST_SKIP;
        ST_STORE:    state_next = ST_STORE;   // Unlimited count
        default:     state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Display enable follows the code's low bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      display_enable_reg <= 1'b0;
    end else if (is_cmd && data_sync2_reg == CMD_SCREEN_OFF) begin
      display_enable_reg <= 1'b0;
    end else if (is_cmd && data_sync2_reg == CMD_SCREEN_ON) begin
      display_enable_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      screen_attribute_reg <= RST_BYTE;
    end else if (is_param && state_reg == ST_SCREEN_1) begin
      screen_attribute_reg <= data_sync2_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cursor_width_reg        <= RST_BYTE;
      cursor_height_shape_reg <= RST_BYTE;
    end else if (is_param && state_reg == ST_SHAPE_1) begin
      cursor_width_reg <= {4'h0, data_sync2_reg[SIZE_FIELD_MSB:0]};
    end else if (is_param && state_reg == ST_SHAPE_2) begin
      cursor_height_shape_reg <= {data_sync2_reg[CURSOR_BLOCK_BIT], 3'h0,
                                  data_sync2_reg[SIZE_FIELD_MSB:0]};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cursor_direction_reg <= RST_BYTE;
    end else if (is_cmd && data_sync2_reg[7:2] == CMD_DIR_PREFIX) begin
      cursor_direction_reg <= {6'h00, data_sync2_reg[DIRECTION_MSB:0]};
    end
  end

  // Cursor: loaded by parameters, stepped after each stored byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cursor_address_low_reg  <= RST_BYTE;
      cursor_address_high_reg <= RST_BYTE;
    end else if (is_param && state_reg == ST_LOAD_1) begin
      cursor_address_low_reg <= data_sync2_reg;
    end else if (is_param && state_reg == ST_LOAD_2) begin
      cursor_address_high_reg <= data_sync2_reg;
    end else if (is_param && state_reg == ST_STORE) begin
      {cursor_address_high_reg, cursor_address_low_reg} <=
        step_addr({cursor_address_high_reg, cursor_address_low_reg},
                  cursor_direction_reg[DIRECTION_MSB:0], line_pitch);
    end
  end

  // Write uses the address before the step
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem_write_en   <= 1'b0;
      mem_write_addr <= RST_ADDR;
      mem_write_data <= RST_BYTE;
    end else begin
      mem_write_en <= is_param && state_reg == ST_STORE;
      if (is_param && state_reg == ST_STORE) begin
        mem_write_addr <= {cursor_address_high_reg, cursor_address_low_reg};
        mem_write_data <= data_sync2_reg;
      end
    end
  end

  // Registered copies keep every output straight from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      display_enable      <= 1'b0;
      cursor_flash_select <= 2'h0;
      block1_show         <= 2'h0;
      block2_4_show       <= 2'h0;
      block3_show         <= 2'h0;
      cursor_width_field  <= 4'h0;
      cursor_height_field <= 4'h0;
      cursor_block_select <= 1'b0;
      cursor_direction    <= 2'h0;
      cursor_address      <= RST_ADDR;
    end else begin
      display_enable      <= display_enable_reg;
      cursor_flash_select <= screen_attribute_reg[FLASH_LSB +: 2];
      block1_show         <= screen_attribute_reg[BLOCK1_LSB +: 2];
      block2_4_show       <= screen_attribute_reg[BLOCK2_4_LSB +: 2];
      block3_show         <= screen_attribute_reg[BLOCK3_LSB +: 2];
      cursor_width_field  <= cursor_width_reg[SIZE_FIELD_MSB:0];
      cursor_height_field <= cursor_height_shape_reg[SIZE_FIELD_MSB:0];
      cursor_block_select <= cursor_height_shape_reg[CURSOR_BLOCK_BIT];
      cursor_direction    <= cursor_direction_reg[DIRECTION_MSB:0];
      cursor_address      <= {cursor_address_high_reg, cursor_address_low_reg};
    end
  end
endmodule : lcdcmd_decoder

// *** logic/lcdcmd_pkg.sv ***
package lcdcmd_pkg;
  // Command codes
  localparam logic [7:0] CMD_SCREEN_OFF    = 8'h58;
  localparam logic [7:0] CMD_SCREEN_ON     = 8'h59;
  localparam logic [7:0] CMD_CURSOR_LOAD   = 8'h46;
  localparam logic [7:0] CMD_CURSOR_SHAPE  = 8'h5D;
  localparam logic [7:0] CMD_MEMORY_STORE  = 8'h42;
  localparam logic [5:0] CMD_DIR_PREFIX    = 6'h13;   // 4Ch..4Fh, low two bits carry direction
  localparam logic [7:0] CMD_DIR_RIGHT     = 8'h4C;
  localparam logic [7:0] CMD_DIR_DOWN      = 8'h4F;

  // Register offsets
  localparam logic [7:0] OFS_DISPLAY_ENABLE   = 8'h09;
  localparam logic [7:0] OFS_SCREEN_ATTRIBUTE = 8'h0A;
  localparam logic [7:0] OFS_CURSOR_WIDTH     = 8'h15;
  localparam logic [7:0] OFS_CURSOR_HEIGHT    = 8'h16;
  localparam logic [7:0] OFS_CURSOR_DIRECTION = 8'h17;
  localparam logic [7:0] OFS_CURSOR_ADDR_LOW  = 8'h1C;
  localparam logic [7:0] OFS_CURSOR_ADDR_HIGH = 8'h1D;

  // Field positions
  localparam int DISPLAY_ENABLE_BIT  = 0;
  localparam int FLASH_LSB           = 0;
  localparam int BLOCK1_LSB          = 2;
  localparam int BLOCK2_4_LSB        = 4;
  localparam int BLOCK3_LSB          = 6;
  localparam int SIZE_FIELD_MSB      = 3;
  localparam int CURSOR_BLOCK_BIT    = 7;
  localparam int DIRECTION_MSB       = 1;

  // Direction encodings
  localparam logic [1:0] DIR_RIGHT = 2'h0;
  localparam logic [1:0] DIR_LEFT  = 2'h1;
  localparam logic [1:0] DIR_UP    = 2'h2;
  localparam logic [1:0] DIR_DOWN  = 2'h3;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_SCREEN_1 = 3'b001,
    ST_LOAD_1   = 3'b010,
    ST_LOAD_2   = 3'b011,
    ST_SHAPE_1  = 3'b100,
    ST_SHAPE_2  = 3'b101,
    ST_STORE    = 3'b110,
    ST_SKIP     = 3'b111
  } lcdcmd_state_t;
endpackage : lcdcmd_pkg

// *** verif/lcdcmd_decoder_properties.sv ***
module lcdcmd_properties (
  // Clock, reset, host pins
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        host_is_command,
  input wire logic [7:0]  host_data,
  input wire logic [15:0] line_pitch,
  // Decoder outputs
  input wire logic        display_enable,
  input wire logic [1:0]  cursor_flash_select,
  input wire logic [1:0]  block1_show,
  input wire logic [1:0]  block2_4_show,
  input wire logic [1:0]  block3_show,
  input wire logic [3:0]  cursor_width_field,
  input wire logic [3:0]  cursor_height_field,
  input wire logic        cursor_block_select,
  input wire logic [1:0]  cursor_direction,
  input wire logic [15:0] cursor_address,
  input wire logic        mem_write_en,
  input wire logic [15:0] mem_write_addr,
  input wire logic [7:0]  mem_write_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import lcdcmd_pkg::*;
  logic [15:0] last_reg;
  logic [7:0]  attr;
  logic [4:0]  shape;
  assign attr  = {block3_show, block2_4_show, block1_show, cursor_flash_select};
  assign shape = {cursor_block_select, cursor_height_field};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Store address held past the pulse, the port may move on
  always_ff @(posedge sys_clk, posedge rst) begin
    if (rst) last_reg <= 16'h0000;
    else if (mem_write_en) last_reg <= mem_write_addr;
  end
  // Pins pass two sync flops first; depths pick a sample inside the strobe's high time
  a_store_single: assert property (
    mem_write_en |=> !mem_write_en) else $error("store pulse too long");
  a_store_data: assert property (
    mem_write_en |-> !$past(host_is_command, 2) && mem_write_data == $past(host_data, 2))
    else $error("stored byte wrong");
  a_store_addr: assert property (
    mem_write_en |-> mem_write_addr == cursor_address) else $error("store address wrong");
  a_step_right: assert property (
    mem_write_en && cursor_direction == DIR_RIGHT
      |-> ##[1:2] cursor_address == last_reg + 16'h1) else $error("right step wrong");
  a_step_left: assert property (
    mem_write_en && cursor_direction == DIR_LEFT
      |-> ##[1:2] cursor_address == last_reg - 16'h1) else $error("left step wrong");
  a_step_up: assert property (
    mem_write_en && cursor_direction == DIR_UP
      |-> ##[1:2] cursor_address == last_reg - line_pitch) else $error("up step wrong");
  a_step_down: assert property (
    mem_write_en && cursor_direction == DIR_DOWN
      |-> ##[1:2] cursor_address == last_reg + line_pitch) else $error("down step wrong");
  a_screen_on: assert property (
    $rose(display_enable)
      |-> $past(host_is_command, 3) && $past(host_data, 3) == CMD_SCREEN_ON)
    else $error("display on wrong");
  a_screen_off: assert property (
    $fell(display_enable)
      |-> $past(host_is_command, 3) && $past(host_data, 3) == CMD_SCREEN_OFF)
    else $error("display off wrong");
  a_attr_load: assert property (
    $changed(attr) |-> !$past(host_is_command, 3) && attr == $past(host_data, 3))
    else $error("attr");
  a_width_load: assert property (
    $changed(cursor_width_field)
      |-> !$past(host_is_command, 3) && cursor_width_field == $past(host_data[3:0], 3))
    else $error("width");
  a_shape_load: assert property (
    $changed(shape)
      |-> !$past(host_is_command, 3)
        && shape == {$past(host_data[7], 3), $past(host_data[3:0], 3)})
    else $error("shape");
  a_dir_code: assert property (
    $changed(cursor_direction)
      |-> $past(host_is_command, 3) && $past(host_data[7:2], 3) == CMD_DIR_PREFIX
        && cursor_direction == $past(host_data[1:0], 3))
    else $error("direction");
endmodule : lcdcmd_properties

bind lcdcmd_decoder lcdcmd_properties u_props (.sys_clk, .rst, .host_is_command, .host_data,
  .line_pitch, .display_enable, .cursor_flash_select, .block1_show, .block2_4_show,
  .block3_show, .cursor_width_field, .cursor_height_field, .cursor_block_select,
  .cursor_direction, .cursor_address, .mem_write_en, .mem_write_addr, .mem_write_data);

// *** verif/lcdcmd_host_model.sv ***
module lcdcmd_host_model (
  // Host pins
  output logic       host_write_strobe,
  output logic       host_is_command,
  output logic [7:0] host_data,
  // Clock
  input  wire  logic sys_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_write_strobe = 1'b0;
    host_is_command   = 1'b0;
    host_data         = 8'h00;
  end
  // Four cycles each way, one above the decoder's floor
  task automatic send(input logic cmd, input logic [7:0] b);
    @(posedge sys_clk) #1;
    host_is_command = cmd;
    host_data       = b;
    repeat (4) @(posedge sys_clk);
    #1 host_write_strobe = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 host_write_strobe = 1'b0;
    host_data = ~b; // Released bus shows no stale byte
    repeat (4) @(posedge sys_clk);
  endtask : send
endmodule : lcdcmd_host_model

// *** verif/test_lcd_cursor_display_cmd_decoder.sv ***
module test_lcd_cursor_display_cmd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import lcdcmd_pkg::*;
  logic        sys_clk, rst, host_write_strobe, host_is_command, display_enable;
  logic        cursor_block_select, mem_write_en;
  logic [7:0]  host_data, mem_write_data;
  logic [15:0] line_pitch, cursor_address, mem_write_addr;
  logic [1:0]  cursor_flash_select, block1_show, block2_4_show, block3_show, cursor_direction;
  logic [3:0]  cursor_width_field, cursor_height_field;
  int          num_errors, n_checks, cycles;
  logic [23:0] seen[$];
  lcdcmd_decoder uut (.sys_clk, .rst, .host_write_strobe, .host_is_command, .host_data,
    .line_pitch, .display_enable, .cursor_flash_select, .block1_show, .block2_4_show,
    .block3_show, .cursor_width_field, .cursor_height_field, .cursor_block_select,
    .cursor_direction, .cursor_address, .mem_write_en, .mem_write_addr, .mem_write_data);
  lcdcmd_host_model host (.host_write_strobe, .host_is_command, .host_data, .sys_clk);
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic t_screen;
    host.send(1'b1, CMD_SCREEN_ON);
    host.send(1'b0, 8'hA9);
    chk("enable", 24'h1, display_enable);
    chk("attr", 24'hA9, {block3_show, block2_4_show, block1_show, cursor_flash_select});
    host.send(1'b1, CMD_SCREEN_OFF);
    host.send(1'b0, 8'h56);
    host.send(1'b0, 8'h00);
    chk("enable", 24'h0, display_enable);
    chk("flash", 24'h2, cursor_flash_select);
    chk("block1", 24'h1, block1_show);
    chk("block3 block2_4", 24'h5, {block3_show, block2_4_show});
  endtask : t_screen
  task automatic t_cursor;
    host.send(1'b1, CMD_CURSOR_LOAD);
    host.send(1'b0, 8'h34);
    host.send(1'b0, 8'h12);
    chk("cursor", 24'h1234, cursor_address);
    host.send(1'b1, CMD_CURSOR_SHAPE);
    host.send(1'b0, 8'hF4);
    host.send(1'b0, 8'h86);
    host.send(1'b0, 8'h0F);
    chk("width", 24'h4, cursor_width_field);
    chk("height", 24'h6, cursor_height_field);
    chk("shape", 24'h1, cursor_block_select);
  endtask : t_cursor
  task automatic t_dir;
    for (int i = 3; i >= 0; i--) begin
      host.send(1'b1, CMD_DIR_RIGHT | 8'(i));
      chk("direction", 24'(i), cursor_direction);
    end
  endtask : t_dir
  task automatic t_store;
    logic [23:0] exp_tab [7] = '{24'hFFFE41, 24'hFFFF42, 24'h000043, 24'h000100, 24'h002900,
                                 24'h005120, 24'h002920};
    host.send(1'b1, CMD_CURSOR_LOAD);
    host.send(1'b0, 8'hFE);
    host.send(1'b0, 8'hFF);
    seen.delete();
    host.send(1'b1, CMD_MEMORY_STORE);
    for (int i = 0; i < 3; i++) host.send(1'b0, 8'h41 + 8'(i));
    host.send(1'b1, CMD_DIR_DOWN);
    host.send(1'b1, CMD_MEMORY_STORE);
    repeat (2) host.send(1'b0, 8'h00);
    host.send(1'b1, CMD_DIR_RIGHT | 8'h02);
    host.send(1'b1, CMD_MEMORY_STORE);
    host.send(1'b0, 8'h20);
    host.send(1'b1, CMD_DIR_RIGHT | 8'h01);
    host.send(1'b1, CMD_MEMORY_STORE);
    host.send(1'b0, 8'h20);
    chk("stores", 24'd7, 24'(seen.size()));
    for (int i = 0; i < 7 && i < seen.size(); i++) chk("store", exp_tab[i], seen[i]);
    chk("cursor", 24'h0028, cursor_address);
  endtask : t_store
  always @(posedge sys_clk) begin
    if (mem_write_en === 1'b1) seen.push_back({mem_write_addr, mem_write_data});
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    rst        = 1'b1;
    line_pitch = 16'h0028;
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("reset", 24'h0, {display_enable, cursor_address, cursor_direction});
    t_screen();
    t_cursor();
    t_dir();
    t_store();
    stop_test();
  end
endmodule : test_lcd_cursor_display_cmd_decoder
